// ### pkg/adc_cfg_pkg.sv
package adc_cfg_pkg;
    // Configuration word layout
    localparam int WORD_W = 14;
    localparam int COUNT_W = 4;
    localparam int CHAN_W = 3;
    localparam int CHAN_LSB = 7;
    localparam int BAND_POS = 6;
    localparam int REF_LSB = 3;
    localparam int REF_W = 3;
    localparam int ORDER_LSB = 1;
    localparam int ORDER_W = 2;
    localparam logic [WORD_W-1:0] WORD_RESET = 14'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 4'h1;
    localparam logic [CHAN_W-1:0] CHAN_ONE = 3'h1;
    localparam logic [CHAN_W-1:0] CHAN_FIRST = 3'h0;

    // Reference and buffer select codes
    localparam logic [REF_W-1:0] REF_INT_LOW = 3'h0;
    localparam logic [REF_W-1:0] REF_INT_HIGH = 3'h1;
    localparam logic [REF_W-1:0] REF_EXT_TEMP = 3'h2;
    localparam logic [REF_W-1:0] REF_EXT_BUF_TEMP = 3'h3;
    localparam logic [REF_W-1:0] REF_RESVD_A = 3'h4;
    localparam logic [REF_W-1:0] REF_RESVD_B = 3'h5;
    localparam logic [REF_W-1:0] REF_EXT_ALL_OFF = 3'h6;
    localparam logic [REF_W-1:0] REF_EXT_BUF = 3'h7;

    // Scan order modes, in field code order
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_UPDATE,
        MODE_SCAN_TEMP,
        MODE_SCAN
    } scan_order_field_e;

    // Analog reference side controls
    typedef struct packed {
        logic int_ref_en;
        logic ref_high;
        logic buffer_en;
        logic temp_en;
        logic ext_ref;
    } analog_ctrl_s;

    localparam analog_ctrl_s ANALOG_RESET = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
endpackage

// ### rtl/adc_config_word_decoder.sv
`timescale 1ns/1ps
module adc_config_word_decoder
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Serial pins from the host
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    // Converter timing
    input wire logic conv_end_in,
    // Analog controls
    output adc_cfg_pkg::analog_ctrl_s analog_out,
    output logic quarter_bw_out,
    // Sequencer outputs
    output logic [adc_cfg_pkg::CHAN_W-1:0] channel_out,
    output logic temp_conv_out,
    // Status
    output logic [adc_cfg_pkg::WORD_W-1:0] config_word_out,
    output logic word_ready_out
);

    // Pin synchronisers
    logic sck_meta;
    logic sck_sync;
    logic sck_prev;
    logic din_meta;
    logic din_sync;
    logic sck_rise;

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sck_meta <= 1'b0;
            sck_sync <= 1'b0;
            sck_prev <= 1'b0;
            din_meta <= 1'b0;
            din_sync <= 1'b0;
        end
        else
        begin
            sck_meta <= serial_clock_in;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
            din_meta <= serial_data_in;
            din_sync <= din_meta;
        end
    end

    assign sck_rise = sck_sync && !sck_prev;

    // Shift register state
    logic [adc_cfg_pkg::WORD_W-1:0] shift_word;
    logic [adc_cfg_pkg::COUNT_W-1:0] bit_count;
    logic word_ready;
    logic [adc_cfg_pkg::WORD_W-1:0] next_shift_word;
    logic [adc_cfg_pkg::COUNT_W-1:0] next_bit_count;

    // Word fields as shifted in
    logic [adc_cfg_pkg::REF_W-1:0] new_ref;
    logic [adc_cfg_pkg::CHAN_W-1:0] new_last;
    adc_cfg_pkg::scan_order_field_e new_order;

    assign word_ready = bit_count == adc_cfg_pkg::COUNT_W'(adc_cfg_pkg::WORD_W);
    assign new_ref = shift_word[adc_cfg_pkg::REF_LSB +: adc_cfg_pkg::REF_W];
    assign new_last = shift_word[adc_cfg_pkg::CHAN_LSB +: adc_cfg_pkg::CHAN_W];
    assign new_order = adc_cfg_pkg::scan_order_field_e'(
        shift_word[adc_cfg_pkg::ORDER_LSB +: adc_cfg_pkg::ORDER_W]);

    // Shift next state; conversion end drops any count
    always_comb
    begin
        next_shift_word = shift_word;
        next_bit_count = bit_count;
        if (conv_end_in)
        begin
            next_bit_count = '0;
        end
        else if (sck_rise && !word_ready)
        begin
            next_shift_word = {shift_word[adc_cfg_pkg::WORD_W-2:0], din_sync};
            next_bit_count = bit_count + adc_cfg_pkg::COUNT_ONE;
        end
    end

    // Shift registers
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            shift_word <= adc_cfg_pkg::WORD_RESET;
            bit_count <= '0;
        end
        else
        begin
            shift_word <= next_shift_word;
            bit_count <= next_bit_count;
        end
    end

    // Applied configuration and sequencer state
    logic apply;
    adc_cfg_pkg::scan_order_field_e run_mode;
    adc_cfg_pkg::scan_order_field_e next_run_mode;
    adc_cfg_pkg::analog_ctrl_s next_analog;
    logic next_quarter_bw;
    logic [adc_cfg_pkg::WORD_W-1:0] next_config_word;
    logic [adc_cfg_pkg::CHAN_W-1:0] next_channel;
    logic next_temp_conv;
    logic [adc_cfg_pkg::CHAN_W-1:0] last_chan;
    logic restart;

    assign apply = conv_end_in && word_ready;

    // Decode and sequence at conversion end
    always_comb
    begin
        next_analog = analog_out;
        next_quarter_bw = quarter_bw_out;
        next_config_word = config_word_out;
        next_run_mode = run_mode;
        next_channel = channel_out;
        next_temp_conv = temp_conv_out;
        last_chan = config_word_out[adc_cfg_pkg::CHAN_LSB +: adc_cfg_pkg::CHAN_W];
        restart = 1'b0;
        if (apply)
        begin
            next_config_word = shift_word;
            last_chan = new_last;
            next_quarter_bw = !shift_word[adc_cfg_pkg::BAND_POS];
            case (new_ref)
                adc_cfg_pkg::REF_INT_LOW: next_analog = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
                adc_cfg_pkg::REF_INT_HIGH: next_analog = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
                adc_cfg_pkg::REF_EXT_TEMP: next_analog = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
                adc_cfg_pkg::REF_EXT_BUF_TEMP:
                    next_analog = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
                adc_cfg_pkg::REF_EXT_ALL_OFF:
                    next_analog = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
                adc_cfg_pkg::REF_EXT_BUF: next_analog = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
                default: next_analog = analog_out; // Reserved codes hold settings
            endcase
            if (new_order != adc_cfg_pkg::MODE_UPDATE)
            begin
                next_run_mode = new_order;
                restart = 1'b1;
            end
        end
        if (conv_end_in)
        begin
            case (next_run_mode)
                adc_cfg_pkg::MODE_SCAN_TEMP:
                begin
                    if (restart || temp_conv_out)
                    begin
                        next_channel = adc_cfg_pkg::CHAN_FIRST;
                        next_temp_conv = 1'b0;
                    end
                    else if (channel_out >= last_chan)
                    begin
                        next_temp_conv = 1'b1;
                    end
                    else
                    begin
                        next_channel = channel_out + adc_cfg_pkg::CHAN_ONE;
                    end
                end
                adc_cfg_pkg::MODE_SCAN:
                begin
                    next_temp_conv = 1'b0;
                    if (restart || temp_conv_out || channel_out >= last_chan)
                    begin
                        next_channel = adc_cfg_pkg::CHAN_FIRST;
                    end
                    else
                    begin
                        next_channel = channel_out + adc_cfg_pkg::CHAN_ONE;
                    end
                end
                default:
                begin
                    next_channel = last_chan;
                    next_temp_conv = 1'b0;
                end
            endcase
        end
    end

    // Applied state registers
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            analog_out <= adc_cfg_pkg::ANALOG_RESET;
            quarter_bw_out <= 1'b1;
            config_word_out <= adc_cfg_pkg::WORD_RESET;
            run_mode <= adc_cfg_pkg::MODE_OFF;
            channel_out <= adc_cfg_pkg::CHAN_FIRST;
            temp_conv_out <= 1'b0;
            word_ready_out <= 1'b0;
        end
        else
        begin
            analog_out <= next_analog;
            quarter_bw_out <= next_quarter_bw;
            config_word_out <= next_config_word;
            run_mode <= next_run_mode;
            channel_out <= next_channel;
            temp_conv_out <= next_temp_conv;
            word_ready_out <= next_bit_count == adc_cfg_pkg::COUNT_W'(adc_cfg_pkg::WORD_W);
        end
    end

    // Checks on decode and sequencing
    property p_band_quarter;
        @(posedge clock_in) disable iff (rst_in)
        apply && !shift_word[adc_cfg_pkg::BAND_POS] |=> quarter_bw_out;
    endproperty
    a_band_quarter: assert property (p_band_quarter) else $error("bandwidth not quarter");

    property p_ref_low;
        @(posedge clock_in) disable iff (rst_in)
        apply && new_ref == adc_cfg_pkg::REF_INT_LOW
        |=> analog_out.int_ref_en && analog_out.temp_en && !analog_out.ref_high;
    endproperty
    a_ref_low: assert property (p_ref_low) else $error("low reference wrong");

    property p_ref_high;
        @(posedge clock_in) disable iff (rst_in)
        apply && new_ref == adc_cfg_pkg::REF_INT_HIGH
        |=> analog_out.int_ref_en && analog_out.ref_high && !analog_out.ext_ref;
    endproperty
    a_ref_high: assert property (p_ref_high) else $error("high reference wrong");

    property p_ref_ext_temp;
        @(posedge clock_in) disable iff (rst_in)
        apply && new_ref == adc_cfg_pkg::REF_EXT_TEMP
        |=> analog_out.ext_ref && analog_out.temp_en && !analog_out.buffer_en;
    endproperty
    a_ref_ext_temp: assert property (p_ref_ext_temp) else $error("ext temp wrong");

    property p_ref_ext_buf_temp;
        @(posedge clock_in) disable iff (rst_in)
        apply && new_ref == adc_cfg_pkg::REF_EXT_BUF_TEMP
        |=> analog_out.ext_ref && analog_out.buffer_en && analog_out.temp_en;
    endproperty
    a_ref_ext_buf_temp: assert property (p_ref_ext_buf_temp) else $error("ext buf wrong");

    property p_ref_off;
        @(posedge clock_in) disable iff (rst_in)
        apply && new_ref == adc_cfg_pkg::REF_EXT_ALL_OFF
        |=> !analog_out.int_ref_en && !analog_out.buffer_en && !analog_out.temp_en;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("power down wrong");

    property p_ref_buf;
        @(posedge clock_in) disable iff (rst_in)
        apply && new_ref == adc_cfg_pkg::REF_EXT_BUF
        |=> analog_out.ext_ref && analog_out.buffer_en && !analog_out.int_ref_en && !analog_out.temp_en;
    endproperty
    a_ref_buf: assert property (p_ref_buf) else $error("buffer only wrong");

    property p_scan_no_temp;
        @(posedge clock_in) disable iff (rst_in)
        conv_end_in && !word_ready && run_mode == adc_cfg_pkg::MODE_SCAN |=> !temp_conv_out;
    endproperty
    a_scan_no_temp: assert property (p_scan_no_temp) else $error("temperature in plain scan");

    property p_wrap;
        @(posedge clock_in) disable iff (rst_in)
        conv_end_in && !word_ready && run_mode == adc_cfg_pkg::MODE_SCAN
        && channel_out == last_chan |=> channel_out == adc_cfg_pkg::CHAN_FIRST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("scan did not wrap");

    property p_temp_step;
        @(posedge clock_in) disable iff (rst_in)
        conv_end_in && !word_ready && run_mode == adc_cfg_pkg::MODE_SCAN_TEMP
        && !temp_conv_out && channel_out == last_chan |=> temp_conv_out ##0 !$past(temp_conv_out);
    endproperty
    a_temp_step: assert property (p_temp_step) else $error("temperature skipped");

    property p_partial;
        @(posedge clock_in) disable iff (rst_in)
        conv_end_in && !word_ready |=> $stable(config_word_out) ##1 bit_count < 4'h2;
    endproperty
    a_partial: assert property (p_partial) else $error("partial word applied");

    property p_hold;
        @(posedge clock_in) disable iff (rst_in)
        !conv_end_in |=> $stable(analog_out) && $stable(quarter_bw_out) && $stable(channel_out);
    endproperty
    a_hold: assert property (p_hold) else $error("change outside conversion end");

endmodule // adc_config_word_decoder

// ### tb/cfg_host_model.sv
`timescale 1ns/1ps
// Host side writer that shifts configuration words into the device
module cfg_host_model
(
    // Clock
    input wire logic clock_in,
    // Serial pins toward the device
    output logic serial_clock_out,
    output logic serial_data_out
);
    // Idle levels
    initial
    begin
        serial_clock_out = 1'b0;
        serial_data_out = 1'b0;
    end
    // MSB first, at least four cycles per level so the synchroniser sees every edge
    task automatic send(input logic [13:0] word, input int n);
        for (int i = 13; i > 13 - n; i--)
        begin
            @(posedge clock_in) serial_data_out <= word[i];
            repeat (4) @(posedge clock_in);
            serial_clock_out <= 1'b1;
            repeat (4) @(posedge clock_in);
            serial_clock_out <= 1'b0;
        end
        // Released data line shows the inverse of its last bit
        @(posedge clock_in) serial_data_out <= ~serial_data_out;
    endtask
endmodule // cfg_host_model

// ### tb/adc_config_word_decoder_test.sv
`timescale 1ns/1ps
// Bench for the configuration word decoder
module adc_config_word_decoder_test;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic conv_end_in = 1'b0;
    logic serial_clock;
    logic serial_data;
    adc_cfg_pkg::analog_ctrl_s analog;
    logic quarter_bw;
    logic temp_conv;
    logic word_ready;
    logic [2:0] channel;
    logic [13:0] config_word;
    logic [13:0] applied = 14'h0000;
    int fails = 0;
    int n_tests = 0;
    // Expected analog controls indexed by reference code
    logic [4:0] exp_ref [8] = '{5'h16, 5'h1e, 5'h03, 5'h07, 5'h00, 5'h00, 5'h01, 5'h05};
    // Usable codes only, reserved ones left out
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

    // Clock at 40 MHz
    always #12.5 clock_in = ~clock_in;

    adc_config_word_decoder dut_u
    (
        .clock_in(clock_in), .rst_in(rst_in), .serial_clock_in(serial_clock),
        .serial_data_in(serial_data), .conv_end_in(conv_end_in), .analog_out(analog),
        .quarter_bw_out(quarter_bw), .channel_out(channel), .temp_conv_out(temp_conv),
        .config_word_out(config_word), .word_ready_out(word_ready)
    );
    cfg_host_model host_u
    (
        .clock_in(clock_in), .serial_clock_out(serial_clock), .serial_data_out(serial_data)
    );

    // Verdict and end of run
    task automatic finish_test();
        $display("counts: %0d compared, %0d mismatched", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Compare one value
    task automatic check(input string name, input logic [13:0] exp, input logic [13:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Word from fields, upper stored bits fixed
    function automatic logic [13:0] mk(input logic [2:0] ch, input logic bw,
                                       input logic [2:0] rc, input logic [1:0] md);
        return {4'h5, ch, bw, rc, md, 1'b1};
    endfunction
    // One end-of-conversion pulse, then settle past the update edge
    task automatic pulse();
        @(posedge clock_in) conv_end_in <= 1'b1;
        @(posedge clock_in) conv_end_in <= 1'b0;
        @(posedge clock_in);
        #1;
    endtask
    // Shift a full word and apply it at the next conversion end
    task automatic load(input logic [13:0] w);
        host_u.send(w, 14);
        repeat (6) @(posedge clock_in);
        #1;
        check("word_ready", 14'h0001, 14'(word_ready));
        check("config_word", applied, config_word);
        pulse();
        applied = w;
        check("config_word", applied, config_word);
        check("word_ready", 14'h0000, 14'(word_ready));
    endtask

    // Main sequence; conversions come as often as every third clock
    initial
    begin
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        check("analog", 14'h0016, 14'(analog));
        check("quarter_bw", 14'h0001, 14'(quarter_bw));
        check("channel", 14'h0000, 14'(channel));
        $display("test reset done");
        foreach (codes[i])
        begin
            load(mk(codes[i], i[0], codes[i], 2'h0));
            check("analog", 14'(exp_ref[codes[i]]), 14'(analog));
            check("quarter_bw", 14'(!i[0]), 14'(quarter_bw));
            pulse();
            check("channel", 14'(codes[i]), 14'(channel));
            check("temp", 14'h0000, 14'(temp_conv));
        end
        $display("test reference codes done");
        load(mk(3'h2, 1'b1, 3'h0, 2'h3));
        check("channel", 14'h0000, 14'(channel));
        for (int k = 1; k < 6; k++)
        begin
            pulse();
            check("channel", 14'(k % 3), 14'(channel));
            check("temp", 14'h0000, 14'(temp_conv));
        end
        $display("test plain scan done");
        load(mk(3'h1, 1'b1, 3'h1, 2'h2));
        for (int k = 1; k < 6; k++)
        begin
            pulse();
            check("temp", 14'(k % 3 == 2), 14'(temp_conv));
            if (k % 3 != 2)
                check("channel", 14'(k % 3), 14'(channel));
        end
        $display("test scan with temperature done");
        load(mk(3'h1, 1'b1, 3'h6, 2'h1));
        check("analog", 14'(exp_ref[6]), 14'(analog));
        check("channel", 14'h0000, 14'(channel));
        pulse();
        check("channel", 14'h0001, 14'(channel));
        pulse();
        check("temp", 14'h0001, 14'(temp_conv));
        $display("test update during sequence done");
        host_u.send(mk(3'h3, 1'b0, 3'h7, 2'h0), 10);
        repeat (6) @(posedge clock_in);
        #1;
        check("word_ready", 14'h0000, 14'(word_ready));
        pulse();
        check("config_word", applied, config_word);
        check("analog", 14'(exp_ref[6]), 14'(analog));
        check("quarter_bw", 14'h0000, 14'(quarter_bw));
        $display("test partial word done");
        finish_test();
    end

    // Watchdog far beyond the expected run
    initial
    begin
        repeat (20000) @(posedge clock_in);
        fails++;
        finish_test();
    end
endmodule // adc_config_word_decoder_test
